// ---- tb.sv ----
// Testbench of the two-wire block with a bus master model on its pins.
`timescale 1ns/1ns
`include "tws_defs.svh"
module tb import tws_pkg::*;;
    logic       clk, lclk, rstn, spi, irq, so, soe, sdo, sdoe, a, ml, dl, ie, ge;
    tws_sfr_s   sfr;
    logic [7:0] rdata, v, b;
    logic [15:0] vec;
    int         n_mismatch, n_tests, cyc;
    // Wired lines with pull-ups.
    wire scl = ~(ml | (soe & ~so));
    wire sda = ~(dl | (sdoe & ~sdo));
    wire [7:0] pins = {4'h0, soe, so, sdoe, sdoe & sdo};
    tws_core u_tws_core (.i_sys_clk(clk), .i_resetn(rstn), .i_link_clk(lclk), .i_sfr(sfr),
        .o_sfr_rdata(rdata), .i_spi_select(spi), .i_irq_enable(ie),
        .i_global_irq_enable(ge), .o_core_irq(irq), .o_irq_vector(vec), .i_scl(scl),
        .o_scl_out(so), .o_scl_oe(soe), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(sdoe));
    tws_bus_master u_tws_bus_master (.i_scl(scl), .i_sda(sda), .o_scl_low(ml), .o_sda_low(dl));
    // System clock and unrelated link clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3;
        forever #16 lclk = ~lclk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (e !== g) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        sfr = '{ad, 1'b1, 1'b0, d};
        @(negedge clk);
        sfr = '0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(negedge clk);
        sfr = '{ad, 1'b0, 1'b1, 8'h00};
        @(negedge clk);
        sfr = '0;
        d = rdata;
    endtask
    // Waits for the byte flag, checks status, then makes one data access.
    task automatic svc(input logic [7:0] ce, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        v = 8'h00;
        while (v[0] !== 1'b1 && n < 4000) begin
            rd(`TWS_OFF_CTL, v);
            n++;
        end
        chk("control", ce, v);
        chk("irq", {7'h0, ie & ge}, {7'h0, irq});
        if (w) wr(`TWS_OFF_DATA, d);
        else begin
            rd(`TWS_OFF_DATA, v);
            chk("data", d, v);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // Main sequence.
    initial begin
        sfr = '0;
        rstn = 1'b0;
        spi = 1'b0;
        ie = 1'b1;
        ge = 1'b1;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        rd(`TWS_OFF_CTL, v); chk("ctl", 8'h00, v);
        rd(`TWS_OFF_ADDR0, v); chk("addr0", 8'h55, v);
        rd(`TWS_OFF_ADDR3, v); chk("addr3", 8'h00, v);
        rd(8'h90, v); chk("unmapped", 8'h00, v);
        wr(`TWS_OFF_ADDR2, 8'h23);
        rd(`TWS_OFF_ADDR2, v); chk("addr2", 8'h23, v);
        chk("vector", 8'h3b, vec[7:0]);
        chk("vector hi", 8'h00, vec[15:8]);
        wr(`TWS_OFF_CTL, 8'h68);
        repeat (3) @(negedge clk); chk("pins", 8'h0e, pins);
        wr(`TWS_OFF_CTL, 8'h88);
        repeat (40) @(negedge clk); chk("pins", 8'h08, pins);
        wr(`TWS_OFF_CTL, 8'ha8);
        repeat (40) @(negedge clk); chk("pins", 8'h0c, pins);
        rd(`TWS_OFF_CTL, v); chk("sdi high", 8'hb8, v);
        u_tws_bus_master.o_sda_low = 1'b1;
        // A two-cycle low pulse on the clock is a spike and must not move the data in bit.
        wr(`TWS_OFF_CTL, 8'h88);
        wr(`TWS_OFF_CTL, 8'ha8);
        repeat (40) @(negedge clk);
        rd(`TWS_OFF_CTL, v); chk("spike", 8'hb8, v);
        wr(`TWS_OFF_CTL, 8'h88);
        repeat (40) @(negedge clk);
        wr(`TWS_OFF_CTL, 8'ha8);
        repeat (40) @(negedge clk);
        rd(`TWS_OFF_CTL, v); chk("sdi low", 8'ha8, v);
        u_tws_bus_master.o_sda_low = 1'b0;
        spi = 1'b1;
        repeat (3) @(negedge clk); chk("spi pins", 8'h00, pins);
        spi = 1'b0;
        wr(`TWS_OFF_CTL, 8'h80);
        repeat (40) @(negedge clk);
        fork
            begin
                u_tws_bus_master.start();
                u_tws_bus_master.put(8'h46, a); chk("ack", 8'h01, {7'h0, a});
                u_tws_bus_master.put(8'ha5, a);
                u_tws_bus_master.stop();
            end
            begin
                svc(8'h81, 1'b0, 8'h46);
                svc(8'ha1, 1'b0, 8'ha5);
                svc(8'hb1, 1'b1, 8'h00);
            end
        join
        wr(`TWS_OFF_CTL, 8'h00);
        fork
            begin
                u_tws_bus_master.start();
                u_tws_bus_master.put(8'haa, a);
                u_tws_bus_master.start();
                u_tws_bus_master.put(8'hab, a);
                u_tws_bus_master.get(1'b1, b); chk("tx byte", 8'h3c, b);
                u_tws_bus_master.stop();
            end
            begin
                svc(8'h01, 1'b0, 8'haa);
                svc(8'h13, 1'b1, 8'h3c);
            end
        join
        rd(`TWS_OFF_CTL, v); chk("no flag", 8'h00, v & 8'h01);
        u_tws_bus_master.start();
        u_tws_bus_master.put(8'ha0, a); chk("no match", 8'h00, {7'h0, a});
        u_tws_bus_master.stop();
        fork
            begin
                u_tws_bus_master.start();
                u_tws_bus_master.put(8'haa, a);
                u_tws_bus_master.put(8'h11, a); chk("halt ack", 8'h00, {7'h0, a});
                u_tws_bus_master.stop();
            end
            begin
                svc(8'h01, 1'b0, 8'haa);
                rd(`TWS_OFF_DATA, v);
            end
        join
        wr(`TWS_OFF_CTL, 8'h04);
        wr(`TWS_OFF_CTL, 8'h00);
        ge = 1'b0;
        fork
            begin
                u_tws_bus_master.start();
                u_tws_bus_master.put(8'haa, a); chk("restart ack", 8'h01, {7'h0, a});
                u_tws_bus_master.stop();
            end
            svc(8'h01, 1'b0, 8'haa);
        join
        print_verdict();
    end
endmodule

// ---- tws_bus_master.sv ----
// Behavioural two-wire bus master used as the far side of the slave.
`timescale 1ns/1ns
module tws_bus_master (
    // Resolved line levels.
    input  wire logic i_scl,
    input  wire logic i_sda,
    // Open-drain pulls; high pulls the line low.
    output logic      o_scl_low,
    output logic      o_sda_low
);
    localparam int HALF = 600;
    // Both lines are released at start.
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    // Releases the clock and waits, bounded, while the slave stretches it.
    task automatic scl_up();
        int n;
        n = 0;
        o_scl_low = 1'b0;
        while (i_scl !== 1'b1 && n < 3000) begin
            #10;
            n++;
        end
        #HALF;
    endtask
    task automatic start();
        o_sda_low = 1'b0;
        scl_up();
        o_sda_low = 1'b1;
        #HALF;
        o_scl_low = 1'b1;
        #HALF;
    endtask
    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low = ~b[i];
            scl_up();
            o_scl_low = 1'b1;
            #HALF;
        end
        o_sda_low = 1'b0;
        scl_up();
        ack = ~i_sda;
        o_scl_low = 1'b1;
        #HALF;
    endtask
    // Reads a byte and answers with an acknowledge or a refusal.
    task automatic get(input logic nack, output logic [7:0] b);
        o_sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            scl_up();
            b[i] = i_sda;
            o_scl_low = 1'b1;
            #HALF;
        end
        o_sda_low = ~nack;
        scl_up();
        o_scl_low = 1'b1;
        #HALF;
        o_sda_low = 1'b0;
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        scl_up();
        o_sda_low = 1'b0;
        #HALF;
    endtask
endmodule

// ---- tws_core.sv ----
// Two-wire interface: software master pin control and hardware slave controller.
`timescale 1ns/1ns
`include "tws_defs.svh"

// Operation
// RULE_01: Any data register access clears the pending byte-done flag and interrupt.
// RULE_02: A second data register access per flag halts the slave until restart.
// RULE_03: Slave answers any of four programmable seven-bit addresses.
// RULE_04: Repeated START without STOP restarts address reception.
// RULE_05: Spikes shorter than 50 ns on both lines are rejected.
// RULE_06: Master select bit set gives software master, clear gives slave.
// RULE_07: Master mode: drive bit set drives data pin to data out bit.
// RULE_08: Master mode: clock pin always driven from clock out bit.
// RULE_09: Drive bit clear: data in bit captures data pin on clock rise.
// RULE_10: Software sequences the master bits to form whole bus transfers.
// RULE_11: Reset selects slave mode with address and data registers at defaults.
// RULE_12: Interface works only while the SPI select bit is clear.
// RULE_13: Flag set only after START, matching address and direction bit.
// RULE_14: Core interrupt needs the block enable and the global enable.
// RULE_15: The interrupt vector is 003b at the end of each byte.
// RULE_16: First byte puts the address and direction bit in the data register.
// RULE_17: Slave transmit flag holds the master's direction bit.
// RULE_18: After a valid address the clock is held low while flagged.
// RULE_19: Flag set after a byte with ACK; none after NACK.
// RULE_20: Flags continue for every byte until STOP or reset.
// RULE_21: STOP, or NACK ending a sequence, returns the slave to idle.
// RULE_22: Restart bit forces the slave back to idle.
// RULE_23: Extra address registers are writable at any time.
// RULE_24: Hardware loads a two-bit source code for each flag.
// RULE_25: Stop interrupt enable makes a STOP after valid START flag.
// RULE_26: Lines are synchronised and a change needs a stable count.
module tws_core
    import tws_pkg::*;
#(
    parameter int FILT_CYC = `TWS_FILT_CYC
) (
    // System clock and reset.
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    // Link clock for the line filters.
    input  wire logic       i_link_clk,
    // Register port.
    input  wire tws_sfr_s   i_sfr,
    output logic [7:0]      o_sfr_rdata,
    // Enables held in other core registers.
    input  wire logic       i_spi_select,
    input  wire logic       i_irq_enable,
    input  wire logic       i_global_irq_enable,
    // Interrupt request and its vector.
    output logic            o_core_irq,
    output logic [15:0]     o_irq_vector,
    // Bus pins.
    input  wire logic       i_scl,
    output logic            o_scl_out,
    output logic            o_scl_oe,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe
);

    // Link domain reset pipeline, pin synchronisers and spike filters.
    logic [1:0]  lrst_q;
    logic [2:0]  lsync_q [2];
    logic [2:0]  lcnt_q  [2];
    logic [1:0]  lfilt_q;
    wire  [1:0]  pin_in = {i_scl, i_sda};

    always_ff @(posedge i_link_clk) begin
        lrst_q <= {lrst_q[0], i_resetn};
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            wire stable = lsync_q[g][1] == lsync_q[g][2];
            wire differ = lsync_q[g][2] != lfilt_q[g];
            // RULE_05: spike rejection
            // RULE_26: stable count filter
            always_ff @(posedge i_link_clk) begin
                lsync_q[g] <= {lsync_q[g][1:0], pin_in[g]};
                if (!lrst_q[1]) begin
                    lcnt_q[g]  <= 3'h0;
                    lfilt_q[g] <= 1'b1;
                end else if (!stable || !differ) begin
                    lcnt_q[g] <= 3'h0;
                end else if (lcnt_q[g] >= 3'(FILT_CYC - 1)) begin
                    lcnt_q[g]  <= 3'h0;
                    lfilt_q[g] <= lsync_q[g][2];
                end else begin
                    lcnt_q[g] <= lcnt_q[g] + 3'h1;
                end
            end
        end
    endgenerate

    // Filtered levels cross into the system domain through three flops.
    logic [1:0]  xs1_q;
    logic [1:0]  xs2_q;
    logic [1:0]  xs3_q;
    tws_pins_s   lvl_q;
    tws_pins_s   prv_q;

    always_ff @(posedge i_sys_clk) begin
        xs1_q <= lfilt_q;
        xs2_q <= xs1_q;
        xs3_q <= xs2_q;
        if (!i_resetn) begin
            lvl_q <= '{scl: 1'b1, sda: 1'b1};
            prv_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            if (xs2_q[1] == xs3_q[1]) lvl_q.scl <= xs3_q[1];
            if (xs2_q[0] == xs3_q[0]) lvl_q.sda <= xs3_q[0];
            prv_q <= lvl_q;
        end
    end

    // Bus events seen on the filtered lines.
    wire scl_rise  = lvl_q.scl & ~prv_q.scl;
    wire scl_fall  = ~lvl_q.scl & prv_q.scl;
    wire start_det = prv_q.sda & ~lvl_q.sda & lvl_q.scl & prv_q.scl;
    wire stop_det  = ~prv_q.sda & lvl_q.sda & lvl_q.scl & prv_q.scl;

    // Registers.
    logic [7:0]  ctl_q;
    logic [7:0]  addr_q [4];
    logic [7:0]  data_q;
    logic        done_q;
    logic        tx_q;
    logic        sdi_q;
    logic        used_q;
    tws_src_e    src_q;
    tws_state_e  st_q;
    tws_state_e  st_d;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic        rep_q;
    logic        started_q;
    logic        aphase_q;
    logic        ack_ok_q;

    // Register port decode.
    wire acc      = i_sfr.wr | i_sfr.rd;
    wire ctl_wr   = i_sfr.wr && i_sfr.addr == `TWS_OFF_CTL;
    wire data_wr  = i_sfr.wr && i_sfr.addr == `TWS_OFF_DATA;
    wire data_acc = acc && i_sfr.addr == `TWS_OFF_DATA;
    wire [3:0] addr_wr = {i_sfr.wr && i_sfr.addr == `TWS_OFF_ADDR3,
                          i_sfr.wr && i_sfr.addr == `TWS_OFF_ADDR2,
                          i_sfr.wr && i_sfr.addr == `TWS_OFF_ADDR1,
                          i_sfr.wr && i_sfr.addr == `TWS_OFF_ADDR0};

    // Mode and enables.
    // RULE_12: SPI select gate
    wire enabled   = ~i_spi_select;
    wire master_on = enabled & ctl_q[`TWS_B_MODE];
    wire slave_on  = enabled & ~ctl_q[`TWS_B_MODE];
    wire restart   = ctl_q[`TWS_B_RESTART];
    wire stop_ie   = ctl_q[`TWS_B_STOPIE];

    // RULE_03: four address comparators
    wire [3:0] hit;
    generate
        for (g = 0; g < 4; g++) begin : g_match
            assign hit[g] = addr_q[g][6:0] == shift_q[7:1];
        end
    endgenerate
    wire match = |hit;

    // Event terms used by the state machine and the flag.
    wire last_bit  = scl_fall && cnt_q == 4'h8;
    // RULE_02: repeated access fault
    wire acc_fault = slave_on && data_acc && !done_q && used_q && st_q != ST_HALT;
    wire set_ack   = st_q == ST_ACKO && scl_fall;
    wire set_acki  = st_q == ST_ACKI && scl_fall && ack_ok_q;
    // RULE_25: stop after valid start
    wire set_stop  = stop_det && started_q && stop_ie && st_q != ST_HALT;
    wire set_done  = slave_on && !restart && (set_ack || set_acki || set_stop);

    // Slave controller next state.
    always_comb begin
        st_d = st_q;
        if (!slave_on || restart) begin
            // RULE_22: restart forces idle
            st_d = ST_IDLE;
        end else if (st_q == ST_HALT) begin
            st_d = ST_HALT;
        end else if (acc_fault) begin
            st_d = ST_HALT;
        end else if (stop_det) begin
            // RULE_21: stop returns idle
            st_d = ST_IDLE;
        end else if (start_det) begin
            // RULE_04: repeated start accepted
            st_d = ST_ADDR;
        end else begin
            case (st_q)
                ST_IDLE: st_d = ST_IDLE;
                ST_ADDR: begin
                    // RULE_13: match before flag
                    if (last_bit) st_d = match ? ST_ACKO : ST_IDLE;
                end
                ST_RX: begin
                    if (last_bit) st_d = ST_ACKO;
                end
                ST_ACKO: begin
                    if (scl_fall) st_d = ST_HOLD;
                end
                ST_HOLD: begin
                    // RULE_20: continue per byte
                    if (!done_q) st_d = tx_q ? ST_TX : ST_RX;
                end
                ST_TX: begin
                    if (last_bit) st_d = ST_ACKI;
                end
                ST_ACKI: begin
                    // RULE_21: nack ends sequence
                    if (scl_fall) st_d = ack_ok_q ? ST_HOLD : ST_IDLE;
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    // State, bit counter and shifter.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
        end else begin
            st_q <= st_d;
            if (st_d == ST_TX && st_q == ST_HOLD) begin
                shift_q <= data_q;
                cnt_q   <= 4'h0;
            end else if (st_d != st_q || start_det) begin
                // A start in mid-address restarts the bit count as well.
                cnt_q <= 4'h0;
            end else if (scl_rise && (st_q == ST_ADDR || st_q == ST_RX)) begin
                shift_q <= {shift_q[6:0], lvl_q.sda};
                cnt_q   <= cnt_q + 4'h1;
            end else if (scl_rise && st_q == ST_TX) begin
                cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && st_q == ST_TX) begin
                shift_q <= {shift_q[6:0], 1'b1};
            end
        end
    end

    // Transfer bookkeeping: phase, repeat marker, valid start, master acknowledge.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            aphase_q  <= 1'b0;
            rep_q     <= 1'b0;
            started_q <= 1'b0;
            ack_ok_q  <= 1'b0;
        end else begin
            if (st_d == ST_ADDR && st_q != ST_ADDR) begin
                aphase_q <= 1'b1;
                rep_q    <= st_q != ST_IDLE;
            end else if (st_q == ST_HOLD) begin
                aphase_q <= 1'b0;
            end
            if (st_q == ST_ADDR && st_d == ST_ACKO) begin
                started_q <= 1'b1;
            end else if (st_d == ST_IDLE || st_d == ST_HALT) begin
                started_q <= 1'b0;
            end
            if (st_q == ST_ACKI && scl_rise) ack_ok_q <= ~lvl_q.sda;
        end
    end

    // Byte-done flag, access tracking, source code and direction.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            done_q <= 1'b0;
            used_q <= 1'b0;
            src_q  <= SRC_START;
            tx_q   <= 1'b0;
        end else begin
            // RULE_19: set wins over clear
            // RULE_01: access clears flag
            if (set_done) begin
                done_q <= 1'b1;
            end else if (data_acc || restart) begin
                done_q <= 1'b0;
            end
            if (set_done || restart) begin
                used_q <= 1'b0;
            end else if (data_acc && done_q) begin
                used_q <= 1'b1;
            end
            // RULE_24: source code load
            if (set_done) begin
                src_q <= set_stop ? SRC_STOP : !aphase_q ? SRC_DATA
                       : rep_q ? SRC_RSTART : SRC_START;
            end
            // RULE_17: direction from address
            if (set_ack && aphase_q) tx_q <= shift_q[0];
        end
    end

    // Control, address and data registers.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            // RULE_11: slave mode default
            ctl_q     <= `TWS_RST_CTL;
            addr_q[0] <= `TWS_RST_ADDR0;
            addr_q[1] <= `TWS_RST_ADDR;
            addr_q[2] <= `TWS_RST_ADDR;
            addr_q[3] <= `TWS_RST_ADDR;
            data_q    <= `TWS_RST_DATA;
        end else begin
            // RULE_06: mode bit stored
            if (ctl_wr) ctl_q <= i_sfr.wdata;
            // RULE_23: addresses writable anytime
            for (int i = 0; i < 4; i++) begin
                if (addr_wr[i]) addr_q[i] <= i_sfr.wdata;
            end
            // RULE_16: address byte presented
            if (set_ack) begin
                data_q <= shift_q;
            end else if (data_wr) begin
                data_q <= i_sfr.wdata;
            end
        end
    end

    // RULE_09: data in capture
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            sdi_q <= 1'b0;
        end else if (master_on && !ctl_q[`TWS_B_SDE] && scl_rise) begin
            sdi_q <= lvl_q.sda;
        end
    end

    // Control register read view depends on the mode.
    wire [7:0] ctl_rd = ctl_q[`TWS_B_MODE]
        ? {ctl_q[7:5], sdi_q, ctl_q[3], 3'h0}
        : {ctl_q[7], 1'b0, src_q, ctl_q[3:2], tx_q, done_q};

    // Read data select.
    wire [7:0] rd_sel =
        (i_sfr.addr == `TWS_OFF_CTL)   ? ctl_rd    :
        (i_sfr.addr == `TWS_OFF_ADDR0) ? addr_q[0] :
        (i_sfr.addr == `TWS_OFF_ADDR1) ? addr_q[1] :
        (i_sfr.addr == `TWS_OFF_ADDR2) ? addr_q[2] :
        (i_sfr.addr == `TWS_OFF_ADDR3) ? addr_q[3] :
        (i_sfr.addr == `TWS_OFF_DATA)  ? data_q    : 8'h00;

    // Pin drive: master follows the bits, slave pulls low for ACK, data and stretch.
    wire slave_sda_lo = (st_q == ST_ACKO) || (st_q == ST_TX && !shift_q[7]);
    wire scl_oe_d  = master_on || (slave_on && st_q == ST_HOLD);
    wire scl_out_d = master_on & ctl_q[`TWS_B_SCO];
    wire sda_oe_d  = master_on ? ctl_q[`TWS_B_SDE] : slave_on & slave_sda_lo;
    wire sda_out_d = master_on & ctl_q[`TWS_B_SDO];

    // Output registers.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_sfr_rdata <= 8'h00;
            o_core_irq  <= 1'b0;
            o_scl_oe    <= 1'b0;
            o_scl_out   <= 1'b0;
            o_sda_oe    <= 1'b0;
            o_sda_out   <= 1'b0;
        end else begin
            if (i_sfr.rd) o_sfr_rdata <= rd_sel;
            // RULE_14: gated interrupt request
            o_core_irq <= done_q & slave_on & i_irq_enable & i_global_irq_enable;
            // RULE_08: master clock drive
            // RULE_18: stretch while flagged
            o_scl_oe  <= scl_oe_d;
            o_scl_out <= scl_out_d;
            // RULE_07: master data drive
            o_sda_oe  <= sda_oe_d;
            o_sda_out <= sda_out_d;
        end
    end

    // RULE_15: fixed vector
    assign o_irq_vector = `TWS_IRQ_VECTOR;

    // Checks.
    property p_acc_clear;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        data_acc && done_q && !set_done |=> !done_q;
    endproperty
    a_acc_clear: assert property (p_acc_clear) // RULE_01
        else $error("data access did not clear the flag");

    property p_halt_hold;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        acc_fault && !restart |=> st_q == ST_HALT ##1 (st_q == ST_HALT || restart || !slave_on);
    endproperty
    a_halt_hold: assert property (p_halt_hold) // RULE_02
        else $error("second access did not halt the slave");

    property p_no_match;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        slave_on && !restart && st_q == ST_ADDR && last_bit && !match && !stop_det
            && !start_det && !acc_fault |=> st_q == ST_IDLE && !done_q;
    endproperty
    a_no_match: assert property (p_no_match) // RULE_03
        else $error("unmatched address not ignored");

    property p_rstart;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        slave_on && !restart && start_det && st_q != ST_HALT && !acc_fault
            |=> st_q == ST_ADDR && cnt_q == 4'h0;
    endproperty
    a_rstart: assert property (p_rstart) // RULE_04
        else $error("start not accepted");

    property p_master_sda;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        master_on && ctl_q[`TWS_B_SDE] |=> o_sda_oe && o_sda_out == $past(ctl_q[`TWS_B_SDO]);
    endproperty
    a_master_sda: assert property (p_master_sda) // RULE_07
        else $error("master data pin not driven from data out bit");

    property p_master_scl;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        master_on |=> o_scl_oe && o_scl_out == $past(ctl_q[`TWS_B_SCO]);
    endproperty
    a_master_scl: assert property (p_master_scl) // RULE_08
        else $error("master clock pin not following clock out bit");

    property p_spi_off;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_spi_select |=> !o_scl_oe && !o_sda_oe && !o_core_irq;
    endproperty
    a_spi_off: assert property (p_spi_off) // RULE_12
        else $error("pins driven while disabled");

    property p_stretch;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        slave_on && st_q == ST_HOLD && done_q |=> o_scl_oe && !o_scl_out;
    endproperty
    a_stretch: assert property (p_stretch) // RULE_18
        else $error("clock not held low while flagged");

    property p_nack_idle;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        slave_on && !restart && st_q == ST_ACKI && scl_fall && !ack_ok_q && !stop_det
            && !start_det && !acc_fault |=> st_q == ST_IDLE && $stable(done_q);
    endproperty
    a_nack_idle: assert property (p_nack_idle) // RULE_19
        else $error("nack did not return to idle quietly");

    property p_irq_gate;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        o_core_irq |-> $past(i_irq_enable) && $past(i_global_irq_enable) && $past(done_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) // RULE_14
        else $error("interrupt raised without enables");

    c_addr_ack:  cover property (@(posedge i_sys_clk) set_ack && aphase_q);
    c_tx_byte:   cover property (@(posedge i_sys_clk) set_acki);
    c_stop_irq:  cover property (@(posedge i_sys_clk) set_done && set_stop);
    c_halted:    cover property (@(posedge i_sys_clk) st_q == ST_HALT);

endmodule

// ---- tws_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the two-wire block.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// Register offsets on the special function register port.
`define TWS_OFF_CTL       8'he8
`define TWS_OFF_ADDR0     8'h9b
`define TWS_OFF_ADDR1     8'h91
`define TWS_OFF_ADDR2     8'h92
`define TWS_OFF_ADDR3     8'h93
`define TWS_OFF_DATA      8'h9a

// Reset values.
`define TWS_RST_CTL       8'h00
`define TWS_RST_ADDR0     8'h55
`define TWS_RST_ADDR      8'h00
`define TWS_RST_DATA      8'h00

// Control register field positions.
`define TWS_B_SDO         7
`define TWS_B_STOPIE      7
`define TWS_B_SDE         6
`define TWS_B_SCO         5
`define TWS_B_SDI         4
`define TWS_B_MODE        3
`define TWS_B_RESTART     2
`define TWS_B_TX          1
`define TWS_B_DONE        0

// Timing: spike width to reject and the link clock period, both in ns.
`define TWS_SPIKE_NS      50
`define TWS_LINK_NS       32
`define TWS_FILT_CYC      ((`TWS_SPIKE_NS + `TWS_LINK_NS - 1) / `TWS_LINK_NS)

// Interrupt vector address of the block.
`define TWS_IRQ_VECTOR    16'h003b

`endif

// ---- tws_pkg.sv ----
// Types shared by the two-wire block.
package tws_pkg;

    // Slave controller states, Gray coded in declaration order.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACKO = 3'b011,
        ST_HOLD = 3'b010,
        ST_RX   = 3'b110,
        ST_TX   = 3'b111,
        ST_ACKI = 3'b101,
        ST_HALT = 3'b100
    } tws_state_e;

    // Interrupt source codes.
    typedef enum logic [1:0] {
        SRC_START  = 2'b00,
        SRC_RSTART = 2'b01,
        SRC_DATA   = 2'b10,
        SRC_STOP   = 2'b11
    } tws_src_e;

    // One register port request.
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } tws_sfr_s;

    // Levels of the two bus lines.
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_pins_s;

endpackage
